// ==== core_exec_regs.svh ====
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_INSTR 8'h00
`define OFS_WORK 8'h04
`define OFS_STATUS 8'h08
`define OFS_PC 8'h0C
`define OFS_WDOG 8'h10
`define OFS_PRESC 8'h14
`define OFS_CTRL 8'h18
`define OFS_CYCLES 8'h1C
`define OFS_FILE_BASE 8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ST_ZERO_BIT 2
`define ST_PDOWN_BIT 3
`define ST_TIMEOUT_BIT 4
`define ST_PAGE_LSB 5
`define ST_PAGE_MSB 6
`define CTRL_PSA_BIT 0
`define INSTR_DEST_BIT 5

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define STATUS_RESET 8'h18
`define STATUS_MASK 8'h7C
`define WORK_RESET 8'h00
`define PC_RESET 11'h7FF
`define CTRL_RESET 1'h1

// ----------------------------------------------------------------
// Instruction encodings (12-bit words)
// ----------------------------------------------------------------
`define OPC_BRANCH 3'h5
`define OPC_REG_CLEAR 6'h01
`define OPC_DECREMENT 6'h03
`define OPC_COMPLEMENT 6'h09
`define OPC_INCREMENT 6'h0A
`define OPC_DEC_SKIP 6'h0B
`define INSTR_WDOG_CLEAR 12'h004

`endif

// ==== core_exec_pkg.sv ====
package core_exec_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_RDWAIT = 2'b10,
    PH_RDOUT = 2'b11
  } bus_phase_type;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_CLEAR = 3'b001,
    OP_COMPLEMENT = 3'b010,
    OP_DECREMENT = 3'b011,
    OP_DEC_SKIP = 3'b100,
    OP_INCREMENT = 3'b101,
    OP_BRANCH = 3'b110,
    OP_WDOG_CLEAR = 3'b111
  } op_type;

endpackage : core_exec_pkg

// ==== core_instr_exec_subset.sv ====
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_regs.svh"

module core_instr_exec_subset #(
  parameter int FILE_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import core_exec_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  bus_phase_type phase_r;
  bus_phase_type phase_nxt;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  logic [7:0] file_r [FILE_DEPTH];
  logic [7:0] work_r;
  logic [7:0] status_r;
  logic [10:0] pc_r;
  logic [7:0] wdog_r;
  logic [7:0] presc_r;
  logic psa_r;
  logic flush_r;
  logic [31:0] cycles_r;

  // ----------------------------------------------------------------
  // Address phase and decode
  // ----------------------------------------------------------------
  // Only haddr[7:2] is decoded, so the map aliases every 256 bytes, and
  // hsize is ignored: a narrow write still replaces the whole register.
  wire addr_take = hsel && hready && htrans[1];
  wire wr_cycle = (phase_r == PH_WRITE);
  wire wr_instr = wr_cycle && (addr_r == `OFS_INSTR);
  wire wr_work = wr_cycle && (addr_r == `OFS_WORK);
  wire wr_status = wr_cycle && (addr_r == `OFS_STATUS);
  wire wr_ctrl = wr_cycle && (addr_r == `OFS_CTRL);
  wire addr_in_file = (addr_r >= `OFS_FILE_BASE);
  wire [4:0] bus_file_idx = addr_r[6:2];
  wire wr_file = wr_cycle && addr_in_file;

  // A read stalls one cycle in PH_RDWAIT while hrdata_r is loaded
  always_comb begin
    phase_nxt = PH_IDLE;
    case (phase_r)
      PH_RDWAIT: phase_nxt = PH_RDOUT;
      PH_IDLE, PH_WRITE, PH_RDOUT: begin
        if (addr_take) begin
          phase_nxt = hwrite ? PH_WRITE : PH_RDWAIT;
        end
      end
      default: phase_nxt = PH_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= PH_IDLE;
      addr_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      if (addr_take) begin
        addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // The issued word is retired only when no flush is pending; a
  // flushed slot runs as a no-op but still costs one cycle.
  wire [11:0] instr = hwdata[11:0];
  wire [5:0] opc6 = instr[11:6];
  wire [4:0] f_idx = instr[4:0];
  wire dest_file = instr[`INSTR_DEST_BIT];
  wire [8:0] branch_lit = instr[8:0];
  wire exec = wr_instr && !flush_r;

  // Words outside the decoded set, the rest of the instruction set included,
  // retire as no-ops that still advance the program counter.
  op_type op;
  always_comb begin
    op = OP_NOP;
    if (instr[11:9] == `OPC_BRANCH) begin
      op = OP_BRANCH;
    end else if (instr == `INSTR_WDOG_CLEAR) begin
      op = OP_WDOG_CLEAR;
    end else begin
      case (opc6)
        `OPC_REG_CLEAR: op = OP_CLEAR;
        `OPC_COMPLEMENT: op = OP_COMPLEMENT;
        `OPC_DECREMENT: op = OP_DECREMENT;
        `OPC_DEC_SKIP: op = OP_DEC_SKIP;
        `OPC_INCREMENT: op = OP_INCREMENT;
        default: op = OP_NOP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // source select
  wire [7:0] src = file_r[f_idx];
  wire [7:0] src_inc = 8'(src + 8'h01);
  wire [7:0] src_dec = 8'(src - 8'h01);

  logic [7:0] result;
  always_comb begin
    case (op)
      OP_COMPLEMENT: result = ~src;
      OP_DECREMENT: result = src_dec;
      OP_DEC_SKIP: result = src_dec;
      OP_INCREMENT: result = src_inc;
      default: result = 8'h00;
    endcase
  end

  // Named views of the decoded operation; each acts only when exec is high
  wire is_clear = (op == OP_CLEAR);
  wire is_complement = (op == OP_COMPLEMENT);
  wire is_decrement = (op == OP_DECREMENT);
  wire is_dec_skip = (op == OP_DEC_SKIP);
  wire is_increment = (op == OP_INCREMENT);
  wire is_branch = (op == OP_BRANCH);
  wire is_wdog_clear = (op == OP_WDOG_CLEAR);
  wire op_unary = is_complement || is_decrement || is_dec_skip || is_increment;
  wire result_zero = (result == 8'h00);
  wire to_work = exec && op_unary && !dest_file;
  // clear always goes to the file
  wire to_file = exec && ((op_unary && dest_file) || is_clear);
  wire skip_next = exec && is_dec_skip && result_zero;
  wire branch_take = exec && is_branch;
  wire zero_set = exec && is_clear;
  wire zero_upd = exec && (is_complement || is_decrement || is_increment);
  wire wdog_clear = exec && is_wdog_clear;

  // ----------------------------------------------------------------
  // Data register file
  // ----------------------------------------------------------------
  // The file is separate from the working and status registers, so an
  // operand index never aliases them; a bus write and an instruction
  // write cannot fall in one cycle, the instruction is given priority.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_r[i] <= 8'h00;
      end
    end else if (to_file) begin
      file_r[f_idx] <= result;
    end else if (wr_file) begin
      file_r[bus_file_idx] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Working register and status
  // ----------------------------------------------------------------
  logic [7:0] status_nxt;
  always_comb begin
    status_nxt = status_r;
    // Hardware updates come after the software write so that they win
    if (wr_status) begin
      status_nxt = hwdata[7:0] & `STATUS_MASK;
    end
    if (zero_set) begin
      status_nxt[`ST_ZERO_BIT] = 1'b1;
    end
    if (zero_upd) begin
      status_nxt[`ST_ZERO_BIT] = result_zero;
    end
    if (wdog_clear) begin
      status_nxt[`ST_TIMEOUT_BIT] = 1'b1;
      status_nxt[`ST_PDOWN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work_r <= `WORK_RESET;
      status_r <= `STATUS_RESET;
    end else begin
      status_r <= status_nxt;
      if (to_work) begin
        work_r <= result;
      end else if (wr_work) begin
        work_r <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter, flush and cycle count
  // ----------------------------------------------------------------
  // Every issued word is one instruction cycle, flushed or not, so a
  // branch or a taken skip shows as two counted cycles.
  // literal to low bits
  wire [10:0] branch_target = {status_r[`ST_PAGE_MSB:`ST_PAGE_LSB], branch_lit};
  wire [10:0] pc_step = 11'(pc_r + 11'h001);
  wire [10:0] pc_nxt = branch_take ? branch_target : pc_step;
  // A flushed slot can neither branch nor skip, so it always clears the flag
  wire flush_nxt = skip_next || branch_take;
  // Wraps silently; software reads differences, not absolute counts
  wire [31:0] cycles_nxt = 32'(cycles_r + 32'h0000_0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= `PC_RESET;
      flush_r <= 1'b0;
      cycles_r <= 32'h0000_0000;
    end else if (wr_instr) begin
      cycles_r <= cycles_nxt;
      flush_r <= flush_nxt;
      pc_r <= pc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter and shared prescaler
  // ----------------------------------------------------------------
  // With the prescaler on the watchdog the counter advances on each
  // prescaler wrap; otherwise it advances every cycle and the
  // prescaler runs for the general timer.
  // The counter is only 8 bits here; the timeout compare lives outside this block
  wire presc_wrap = (presc_r == 8'hFF);
  wire presc_clear = wdog_clear && psa_r;
  wire wdog_step = !psa_r || presc_wrap;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_r <= 8'h00;
      presc_r <= 8'h00;
      psa_r <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        psa_r <= hwdata[`CTRL_PSA_BIT];
      end
      if (presc_clear) begin
        presc_r <= 8'h00;
      end else begin
        presc_r <= 8'(presc_r + 8'h01);
      end
      if (wdog_clear) begin
        wdog_r <= 8'h00;
      end else if (wdog_step) begin
        wdog_r <= 8'(wdog_r + 8'h01);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and response
  // ----------------------------------------------------------------
  // Reads take one wait state so that hrdata comes from a flop and
  // always reflects a write made in the cycle before.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_in_file) begin
      rd_mux = {24'h00_0000, file_r[bus_file_idx]};
    end else begin
      case (addr_r)
        `OFS_WORK: rd_mux = {24'h00_0000, work_r};
        `OFS_STATUS: rd_mux = {24'h00_0000, status_r};
        `OFS_PC: rd_mux = {21'h00_0000, pc_r};
        `OFS_WDOG: rd_mux = {24'h00_0000, wdog_r};
        `OFS_PRESC: rd_mux = {24'h00_0000, presc_r};
        `OFS_CTRL: rd_mux = {31'h0000_0000, psa_r};
        `OFS_CYCLES: rd_mux = cycles_r;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (phase_r == PH_RDWAIT) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata = hrdata_r;
  // Writes never wait; only the first data cycle of a read is stretched
  assign hreadyout = (phase_r != PH_RDWAIT);
  // Every transfer is OKAY; unmapped addresses read zero
  assign hresp = 1'b0;

  // Inputs that the map does not decode
  wire unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0], htrans[0], hwdata[31:12]};

endmodule : core_instr_exec_subset

`default_nettype wire

// ==== core_exec_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_regs.svh"
module core_exec_monitor #(
  parameter int FILE_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  import core_exec_pkg::*;
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire wr_take = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  a_read_wait: assert property (rd_take |=> s_rd_answer)
    else $error("read answer timing wrong");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside capture");
  a_status_bits: assert property (rd_take && haddr[7:0] == `OFS_STATUS |=>
    s_rd_answer ##0 (hrdata[31:7] == 25'h000_0000 && hrdata[1:0] == 2'h0))
    else $error("status unused bits not zero");
  a_ctr_width: assert property (rd_take && haddr[7:0] == `OFS_PC |=>
    s_rd_answer ##0 hrdata[31:11] == 21'h00_0000)
    else $error("program counter wider than 11 bits");
endmodule : core_exec_monitor
bind core_instr_exec_subset core_exec_monitor #(.FILE_DEPTH(FILE_DEPTH)) mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata));
`default_nettype wire

// ==== ahb_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ahb_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic stuck
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    stuck = 1'b0;
  end
  // Sampled at the rising edge itself, before the slave's flops move on
  task automatic wait_ready(inout int n, output logic [31:0] q);
    logic r;
    do begin
      @(posedge hclk);
      r = hready;
      q = hrdata;
      n++;
    end while (r !== 1'b1 && n < 64);
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready(n, q);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(n, q);
    if (n >= 64) stuck <= 1'b1;
  endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

// ==== core_instr_exec_subset_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "core_exec_regs.svh"
module core_instr_exec_subset_tb_top;
  import core_exec_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hresp, stuck;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, p0;
  int n_errors = 0;
  int compares = 0;
  always #20 hclk = ~hclk;
  core_instr_exec_subset DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  ahb_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .stuck(stuck));
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    host.xfer(1'b0, a, 32'h0000_0000, v);
  endtask : rd
  task automatic cmp(input string nm, input logic [31:0] e, v);
    compares++;
    if (v !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
    end
  endtask : cmp
  task automatic chk(input string nm, input logic [31:0] a, e);
    logic [31:0] v;
    rd(a, v);
    cmp(nm, e, v);
  endtask : chk
  function automatic logic [31:0] op(input logic [5:0] o, input logic d, input logic [4:0] f);
    return {20'h0_0000, o, d, f};
  endfunction : op
  // Prescaler is steered to mid-range first, so a clear and a free run cannot alias
  task automatic wdc(input logic kept);
    logic [31:0] q;
    rd(`OFS_PRESC, q);
    repeat (8'(8'h80 - q[7:0])) @(posedge hclk);
    wr(`OFS_INSTR, 32'h0000_0004);
    rd(`OFS_PRESC, q);
    cmp("prescaler", {31'h0, kept}, {31'h0, q > 32'h0000_0040});
  endtask : wdc
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge stuck) begin
    n_errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("status_rst", `OFS_STATUS, 32'h0000_0018);
    chk("ctr_rst", `OFS_PC, 32'h0000_07FF);
    chk("unmapped", 32'h0000_0040, 32'h0000_0000);
    wr(32'h0000_008C, 32'h0000_0055);
    wr(`OFS_INSTR, op(`OPC_REG_CLEAR, 1'b0, 5'd3));
    chk("clr_file", 32'h0000_008C, 32'h0000_0000);
    chk("clr_zero", `OFS_STATUS, 32'h0000_001C);
    wr(`OFS_INSTR, op(`OPC_COMPLEMENT, 1'b1, 5'd3));
    chk("com_file", 32'h0000_008C, 32'h0000_00FF);
    chk("com_zero", `OFS_STATUS, 32'h0000_0018);
    wr(`OFS_INSTR, op(`OPC_COMPLEMENT, 1'b0, 5'd3));
    chk("com_work", `OFS_WORK, 32'h0000_0000);
    chk("com_keep", 32'h0000_008C, 32'h0000_00FF);
    wr(`OFS_INSTR, op(`OPC_INCREMENT, 1'b1, 5'd3));
    chk("inc_wrap", 32'h0000_008C, 32'h0000_0000);
    chk("inc_zero", `OFS_STATUS, 32'h0000_001C);
    wr(`OFS_INSTR, op(`OPC_DECREMENT, 1'b1, 5'd3));
    chk("dec_wrap", 32'h0000_008C, 32'h0000_00FF);
    chk("dec_zero", `OFS_STATUS, 32'h0000_0018);
    wr(32'h0000_00FC, 32'h0000_0002);
    wr(`OFS_WORK, 32'h0000_0033);
    wr(`OFS_STATUS, 32'h0000_001C);
    wr(`OFS_INSTR, op(`OPC_DEC_SKIP, 1'b1, 5'd31));
    chk("dsz_file", 32'h0000_00FC, 32'h0000_0001);
    rd(`OFS_PC, p0);
    wr(`OFS_INSTR, op(`OPC_DEC_SKIP, 1'b0, 5'd31));
    wr(`OFS_INSTR, op(`OPC_INCREMENT, 1'b1, 5'd31));
    chk("dsz_work", `OFS_WORK, 32'h0000_0000);
    chk("dsz_skip", 32'h0000_00FC, 32'h0000_0001);
    chk("dsz_flag", `OFS_STATUS, 32'h0000_001C);
    chk("dsz_ctr", `OFS_PC, (p0 + 32'h0000_0002) & 32'h0000_07FF);
    wr(`OFS_STATUS, 32'h0000_0058);
    wr(`OFS_INSTR, {20'h0_0000, `OPC_BRANCH, 9'h1FF});
    chk("br_ctr", `OFS_PC, 32'h0000_05FF);
    wr(`OFS_INSTR, op(`OPC_INCREMENT, 1'b1, 5'd31));
    chk("br_flush", 32'h0000_00FC, 32'h0000_0001);
    chk("br_next", `OFS_PC, 32'h0000_0600);
    chk("br_flag", `OFS_STATUS, 32'h0000_0058);
    wr(`OFS_STATUS, 32'h0000_0064);
    wdc(1'b0);
    chk("wdc_flag", `OFS_STATUS, 32'h0000_007C);
    chk("wdc_count", `OFS_WDOG, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0000);
    wdc(1'b1);
    rd(`OFS_WDOG, p0);
    cmp("wdc_wdog", 32'h0000_0001, {31'h0, p0 < 32'h0000_0040});
    chk("cycles", `OFS_CYCLES, 32'h0000_000C);
    results();
  end
endmodule : core_instr_exec_subset_tb_top
`default_nettype wire
